// [rtl/timer_channel_defines.vh]
// register map, field positions and reset values of the timer channel
`ifndef TIMER_CHANNEL_DEFINES_VH
`define TIMER_CHANNEL_DEFINES_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_CHANNEL_CONTROL 32'h40010000
`define ADDR_CHANNEL_MODE 32'h40010004
`define ADDR_STEPPER_GRAY_MODE 32'h40010008
`define ADDR_COUNTER_VALUE_READBACK 32'h40010010
`define ADDR_CAPTURE_COMPARE_A 32'h40010014
`define ADDR_CAPTURE_COMPARE_B 32'h40010018
`define ADDR_COMPARE_LIMIT_C 32'h4001001c
`define ADDR_CHANNEL_STATUS 32'h40010020
`define ADDR_INTERRUPT_ENABLE_SET 32'h40010024
`define ADDR_INTERRUPT_ENABLE_CLEAR 32'h40010028
`define ADDR_INTERRUPT_MASK 32'h4001002c
`define ADDR_WRITE_PROTECT_MODE 32'h400100e4

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_CLOCK_ENABLE 0
`define CTRL_CLOCK_DISABLE 1
`define CTRL_SOFT_TRIGGER 2
`define MODE_WAVEFORM 15
`define MODE_SWTRG_A_LO 22
`define MODE_SWTRG_B_LO 30
`define GRAY_ENABLE_BIT 0
`define GRAY_DOWN_BIT 1
`define WP_ENABLE_BIT 0
`define STAT_OVERFLOW 0
`define STAT_LOAD_OVERRUN 1
`define STAT_MATCH_A 2
`define STAT_MATCH_B 3
`define STAT_MATCH_C 4
`define STAT_LOAD_A 5
`define STAT_LOAD_B 6
`define STAT_EXT_TRIGGER 7
`define STAT_CLOCK_ON 16
`define STAT_MIRROR_A 17
`define STAT_MIRROR_B 18

// ----------------------------------------
// encodings and reset values
// ----------------------------------------
`define EFFECT_NONE 2'h0
`define EFFECT_SET 2'h1
`define EFFECT_CLEAR 2'h2
`define EFFECT_TOGGLE 2'h3
`define COUNT_MAX 32'hffffffff
`define RESET_WORD 32'h00000000

`endif

// [rtl/timer_channel_status_regs.v]
// one timer/counter channel with its status, compare and gray stepper registers on ahb-lite
//
// Overview of operation
// - software trigger acts on lines a and b in waveform mode: none, set, clear or toggle by a 2-bit field each
// - gray enable set: both lines driven by 2-bit gray counter, bit1 picks down
// - gray enable clear: both lines come from the channel's own counter logic
// - stepper mode, a, b and c writes ignored while write protect is set
// - counter value register is read-only and returns the live 32-bit count
// - a and b read-only in capture mode, read-write in waveform mode
// - c register read-write in both modes, subject to write protection
// - overflow flag sets on counter wrap, clears on status read
// - capture mode: overrun flag sets when a or b reloaded before read
// - waveform mode: bits 2 and 3 set on match with a or b
// - bit 4 sets on match with c in either mode, clears on read
// - capture mode: bits 5 and 6 set when a or b captured
// - bit 7 sets on external trigger, clears on status read
// - bit 16 shows live whether counter clock is enabled
// - bits 17 and 18 mirror line levels: pin in capture without gray, driven in waveform or with gray enable set
// - enable-set register sets enables where ones are written, bits 0 to 7
// - enable-clear register clears enables where ones are written
// - mask register reads back current enables per source
// - mode bit 0 is capture, 1 is waveform; gates flags and accesses
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "timer_channel_defines.vh"

module timer_channel_status_regs (
   // clock and reset
   input wire clk,
   input wire reset,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // waveform line a pin
   input wire waveform_line_a_in,
   output wire waveform_line_a_out,
   output wire waveform_line_a_oe,
   // waveform line b pin
   input wire waveform_line_b_in,
   output wire waveform_line_b_out,
   output wire waveform_line_b_oe,
   // external trigger pin
   input wire ext_trigger_in,
   // interrupt
   output wire channel_irq
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [31:0] mode_reg;
   reg [1:0] gray_mode_reg;
   reg write_protect_enable_reg;
   reg [31:0] live_count_reg;
   reg [31:0] capture_compare_a_value_reg;
   reg [31:0] capture_compare_b_value_reg;
   reg [31:0] compare_limit_value_reg;
   reg [7:0] flags_reg;
   reg [7:0] flags_next;
   reg [7:0] irq_enable_reg;
   reg counter_clock_on_reg;
   reg line_a_reg;
   reg line_b_reg;
   reg [1:0] gray_count_reg;
   reg a_unread_reg;
   reg b_unread_reg;
   reg [2:0] sync_a_reg;
   reg [1:0] sync_b_reg;
   reg [2:0] sync_trg_reg;
   reg wr_pending_reg;
   reg [31:0] wr_addr_reg;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   // zero wait states: reads are answered from the address phase edge
   wire access = hsel & htrans[1] & hready;
   wire rd_access = access & ~hwrite;
   wire rd_status = rd_access & (haddr == `ADDR_CHANNEL_STATUS);
   wire rd_a = rd_access & (haddr == `ADDR_CAPTURE_COMPARE_A);
   wire rd_b = rd_access & (haddr == `ADDR_CAPTURE_COMPARE_B);
   wire wr_ok = wr_pending_reg & ~write_protect_enable_reg;
   wire waveform = mode_reg[`MODE_WAVEFORM];
   wire wr_ctrl = wr_pending_reg & (wr_addr_reg == `ADDR_CHANNEL_CONTROL);
   wire wr_mode = wr_ok & (wr_addr_reg == `ADDR_CHANNEL_MODE);
   wire wr_gray = wr_ok & (wr_addr_reg == `ADDR_STEPPER_GRAY_MODE);
   wire wr_a = wr_ok & waveform & (wr_addr_reg == `ADDR_CAPTURE_COMPARE_A);
   wire wr_b = wr_ok & waveform & (wr_addr_reg == `ADDR_CAPTURE_COMPARE_B);
   wire wr_c = wr_ok & (wr_addr_reg == `ADDR_COMPARE_LIMIT_C);
   wire wr_ien = wr_pending_reg & (wr_addr_reg == `ADDR_INTERRUPT_ENABLE_SET);
   wire wr_idis = wr_pending_reg & (wr_addr_reg == `ADDR_INTERRUPT_ENABLE_CLEAR);
   wire wr_wp = wr_pending_reg & (wr_addr_reg == `ADDR_WRITE_PROTECT_MODE);

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always @(posedge clk) begin
      if (reset) begin
         wr_pending_reg <= 1'b0;
         wr_addr_reg <= `RESET_WORD;
      end else if (hready) begin
         wr_pending_reg <= access & hwrite;
         wr_addr_reg <= haddr;
      end
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // stage 0 is read only by stage 1; stages 1 and 2 feed the edge detectors
   always @(posedge clk) begin
      if (reset) begin
         sync_a_reg <= 3'h0;
         sync_b_reg <= 2'h0;
         sync_trg_reg <= 3'h0;
      end else begin
         sync_a_reg <= {sync_a_reg[1:0], waveform_line_a_in};
         sync_b_reg <= {sync_b_reg[0], waveform_line_b_in};
         sync_trg_reg <= {sync_trg_reg[1:0], ext_trigger_in};
      end
   end

   wire pin_a = sync_a_reg[1];
   wire pin_b = sync_b_reg[1];
   wire a_rise = sync_a_reg[1] & ~sync_a_reg[2];
   wire a_fall = ~sync_a_reg[1] & sync_a_reg[2];
   wire ext_trig = sync_trg_reg[1] & ~sync_trg_reg[2];
   wire soft_trig = wr_ctrl & hwdata[`CTRL_SOFT_TRIGGER];

   // ----------------------------------------
   // counter and events
   // ----------------------------------------
   wire counting = counter_clock_on_reg;
   wire overflow = counting & (live_count_reg == `COUNT_MAX);
   wire match_a = counting & (live_count_reg == capture_compare_a_value_reg);
   wire match_b = counting & (live_count_reg == capture_compare_b_value_reg);
   wire match_c = counting & (live_count_reg == compare_limit_value_reg);
   // capture: a loads on rising, b on falling edge of line a
   wire load_a = ~waveform & counting & a_rise;
   wire load_b = ~waveform & counting & a_fall;
   wire overrun = (load_a & a_unread_reg) | (load_b & b_unread_reg);

   always @(posedge clk) begin
      if (reset) begin
         counter_clock_on_reg <= 1'b0;
         live_count_reg <= `RESET_WORD;
      end else begin
         if (wr_ctrl & hwdata[`CTRL_CLOCK_DISABLE])
            counter_clock_on_reg <= 1'b0;
         else if ((wr_ctrl & hwdata[`CTRL_CLOCK_ENABLE]) | soft_trig | ext_trig)
            counter_clock_on_reg <= 1'b1;
         // triggers restart the count from zero
         if (soft_trig | ext_trig)
            live_count_reg <= `RESET_WORD;
         else if (counting)
            live_count_reg <= live_count_reg + 32'h00000001;
      end
   end

   // ----------------------------------------
   // capture / compare registers
   // ----------------------------------------
   always @(posedge clk) begin
      if (reset) begin
         capture_compare_a_value_reg <= `RESET_WORD;
         capture_compare_b_value_reg <= `RESET_WORD;
         compare_limit_value_reg <= `RESET_WORD;
         a_unread_reg <= 1'b0;
         b_unread_reg <= 1'b0;
      end else begin
         if (load_a)
            capture_compare_a_value_reg <= live_count_reg;
         else if (wr_a)
            capture_compare_a_value_reg <= hwdata;
         if (load_b)
            capture_compare_b_value_reg <= live_count_reg;
         else if (wr_b)
            capture_compare_b_value_reg <= hwdata;
         if (wr_c)
            compare_limit_value_reg <= hwdata;
         // a load in the read cycle leaves the register unread again
         a_unread_reg <= load_a | (a_unread_reg & ~rd_a);
         b_unread_reg <= load_b | (b_unread_reg & ~rd_b);
      end
   end

   // ----------------------------------------
   // status flags
   // ----------------------------------------
   always @* begin
      flags_next = flags_reg & ~{8{rd_status}};
      // sets are or-ed after the clear so the event wins
      flags_next[`STAT_OVERFLOW] = flags_next[`STAT_OVERFLOW] | overflow;
      flags_next[`STAT_LOAD_OVERRUN] = flags_next[`STAT_LOAD_OVERRUN] | overrun;
      flags_next[`STAT_MATCH_A] = flags_next[`STAT_MATCH_A] | (waveform & match_a);
      flags_next[`STAT_MATCH_B] = flags_next[`STAT_MATCH_B] | (waveform & match_b);
      flags_next[`STAT_MATCH_C] = flags_next[`STAT_MATCH_C] | match_c;
      flags_next[`STAT_LOAD_A] = flags_next[`STAT_LOAD_A] | load_a;
      flags_next[`STAT_LOAD_B] = flags_next[`STAT_LOAD_B] | load_b;
      flags_next[`STAT_EXT_TRIGGER] = flags_next[`STAT_EXT_TRIGGER] | ext_trig;
   end

   always @(posedge clk) begin
      if (reset)
         flags_reg <= 8'h00;
      else
         flags_reg <= flags_next;
   end

   // ----------------------------------------
   // interrupt enables
   // ----------------------------------------
   always @(posedge clk) begin
      if (reset)
         irq_enable_reg <= 8'h00;
      else if (wr_ien)
         irq_enable_reg <= irq_enable_reg | hwdata[7:0];
      else if (wr_idis)
         irq_enable_reg <= irq_enable_reg & ~hwdata[7:0];
   end

   assign channel_irq = |(flags_reg & irq_enable_reg);

   // ----------------------------------------
   // mode, stepper and protection registers
   // ----------------------------------------
   always @(posedge clk) begin
      if (reset) begin
         mode_reg <= `RESET_WORD;
         gray_mode_reg <= 2'h0;
         write_protect_enable_reg <= 1'b0;
      end else begin
         if (wr_mode)
            mode_reg <= hwdata;
         if (wr_gray)
            gray_mode_reg <= hwdata[1:0];
         if (wr_wp)
            write_protect_enable_reg <= hwdata[`WP_ENABLE_BIT];
      end
   end

   // ----------------------------------------
   // waveform lines
   // ----------------------------------------
   function [0:0] apply_effect;
      input [1:0] effect;
      input level;
      begin
         case (effect)
            `EFFECT_SET: apply_effect = 1'b1;
            `EFFECT_CLEAR: apply_effect = 1'b0;
            `EFFECT_TOGGLE: apply_effect = ~level;
            default: apply_effect = level;
         endcase
      end
   endfunction

   wire [1:0] swtrg_a = mode_reg[`MODE_SWTRG_A_LO+1:`MODE_SWTRG_A_LO];
   wire [1:0] swtrg_b = mode_reg[`MODE_SWTRG_B_LO+1:`MODE_SWTRG_B_LO];
   wire gray_on = gray_mode_reg[`GRAY_ENABLE_BIT];

   // soft trigger has priority over compare effects on the same cycle
   always @(posedge clk) begin
      if (reset) begin
         line_a_reg <= 1'b0;
         line_b_reg <= 1'b0;
      end else if (waveform) begin
         if (soft_trig)
            line_a_reg <= apply_effect(swtrg_a, line_a_reg);
         else if (match_a)
            line_a_reg <= ~line_a_reg;
         if (soft_trig)
            line_b_reg <= apply_effect(swtrg_b, line_b_reg);
         else if (match_b)
            line_b_reg <= ~line_b_reg;
      end
   end

   // gray stepper states, coded as the levels they put on {line b, line a}
   localparam GRAY_00 = 2'h0;
   localparam GRAY_01 = 2'h1;
   localparam GRAY_11 = 2'h3;
   localparam GRAY_10 = 2'h2;
   reg [1:0] gray_up_next;
   reg [1:0] gray_down_next;

   always @* begin
      case (gray_count_reg)
         GRAY_00: begin
            gray_up_next = GRAY_01;
            gray_down_next = GRAY_10;
         end
         GRAY_01: begin
            gray_up_next = GRAY_11;
            gray_down_next = GRAY_00;
         end
         GRAY_11: begin
            gray_up_next = GRAY_10;
            gray_down_next = GRAY_01;
         end
         GRAY_10: begin
            gray_up_next = GRAY_00;
            gray_down_next = GRAY_11;
         end
         default: begin
            gray_up_next = GRAY_00;
            gray_down_next = GRAY_00;
         end
      endcase
   end

   // gray stepper advances once per match with c
   always @(posedge clk) begin
      if (reset)
         gray_count_reg <= 2'h0;
      else if (gray_on & match_c) begin
         if (gray_mode_reg[`GRAY_DOWN_BIT])
            gray_count_reg <= gray_down_next;
         else
            gray_count_reg <= gray_up_next;
      end
   end

   // down: 00 10 11 01 ; up: 00 01 11 10
   assign waveform_line_a_out = gray_on ? gray_count_reg[0] : line_a_reg;
   assign waveform_line_b_out = gray_on ? gray_count_reg[1] : line_b_reg;
   assign waveform_line_a_oe = gray_on | waveform;
   assign waveform_line_b_oe = gray_on | waveform;

   wire mirror_a = waveform_line_a_oe ? waveform_line_a_out : pin_a;
   wire mirror_b = waveform_line_b_oe ? waveform_line_b_out : pin_b;

   // ----------------------------------------
   // read data
   // ----------------------------------------
   reg [31:0] rdata_next;

   always @* begin
      rdata_next = `RESET_WORD;
      case (haddr)
         `ADDR_CHANNEL_MODE: rdata_next = mode_reg;
         `ADDR_STEPPER_GRAY_MODE: rdata_next = {30'h0, gray_mode_reg};
         `ADDR_COUNTER_VALUE_READBACK: rdata_next = live_count_reg;
         `ADDR_CAPTURE_COMPARE_A: rdata_next = capture_compare_a_value_reg;
         `ADDR_CAPTURE_COMPARE_B: rdata_next = capture_compare_b_value_reg;
         `ADDR_COMPARE_LIMIT_C: rdata_next = compare_limit_value_reg;
         `ADDR_CHANNEL_STATUS: begin
            rdata_next[7:0] = flags_reg;
            rdata_next[`STAT_CLOCK_ON] = counter_clock_on_reg;
            rdata_next[`STAT_MIRROR_A] = mirror_a;
            rdata_next[`STAT_MIRROR_B] = mirror_b;
         end
         `ADDR_INTERRUPT_MASK: rdata_next = {24'h000000, irq_enable_reg};
         `ADDR_WRITE_PROTECT_MODE: rdata_next = {31'h0, write_protect_enable_reg};
         default: rdata_next = `RESET_WORD;
      endcase
   end

   always @(posedge clk) begin
      if (reset)
         hrdata <= `RESET_WORD;
      else if (rd_access)
         hrdata <= rdata_next;
   end

endmodule

// [sim/timer_channel_status_regs_chk.sv]
// assertion checker for the timer channel register block
`timescale 1ns/1ps
`include "timer_channel_defines.vh"
module timer_channel_status_regs_chk (
   // clock and reset
   input wire clk,
   input wire reset,
   // bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   // lines and interrupt
   input wire waveform_line_a_out,
   input wire waveform_line_a_oe,
   input wire waveform_line_b_out,
   input wire waveform_line_b_oe,
   input wire channel_irq
);
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   wire rd_taken = hsel && htrans[1] && hready && !hwrite;
   wire wr_taken = hsel && htrans[1] && hready && hwrite;
   wire rd_stat = rd_taken && (haddr == `ADDR_CHANNEL_STATUS);
   reg ier_pend;
   reg ier_seen;
   // irq needs an enable, and enables come only from the set register
   always @(posedge clk) begin
      if (reset) begin
         ier_pend <= 1'b0;
         ier_seen <= 1'b0;
      end else begin
         ier_pend <= wr_taken && (haddr == `ADDR_INTERRUPT_ENABLE_SET);
         if (ier_pend)
            ier_seen <= 1'b1;
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_ready_always: assert property (hreadyout == 1'b1 && hresp == 1'b0)
      else $error("slave stalled or answered with an error");
   a_oe_paired: assert property (waveform_line_a_oe == waveform_line_b_oe)
      else $error("line enables differ");
   a_oe_by_write: assert property ($changed(waveform_line_a_oe) |-> $past(wr_taken, 2))
      else $error("line enable changed without a write");
   a_rdata_holds: assert property (!rd_taken |=> $stable(hrdata))
      else $error("read data changed without a read");
   a_status_spare: assert property (rd_stat |=> hrdata[31:19] == 13'h0 && hrdata[15:8] == 8'h0)
      else $error("spare status bits not zero");
   a_mirror_a: assert property (rd_stat && waveform_line_a_oe |=> hrdata[17] == $past(waveform_line_a_out))
      else $error("line a mirror wrong");
   a_mirror_b: assert property (rd_stat && waveform_line_b_oe |=> hrdata[18] == $past(waveform_line_b_out))
      else $error("line b mirror wrong");
   a_capture_nomatch: assert property (rd_stat && !waveform_line_a_oe |=> hrdata[3:2] == 2'h0)
      else $error("compare flags set in capture mode");
   a_irq_enabled: assert property (channel_irq |-> ier_seen)
      else $error("irq without any enable written");
   cover property (rd_stat && waveform_line_a_oe);
   cover property ($rose(channel_irq));
   cover property ($changed(waveform_line_b_out) && waveform_line_b_oe);
endmodule

bind timer_channel_status_regs timer_channel_status_regs_chk timer_channel_status_regs_chk_inst (
   .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .waveform_line_a_out(waveform_line_a_out), .waveform_line_a_oe(waveform_line_a_oe),
   .waveform_line_b_out(waveform_line_b_out), .waveform_line_b_oe(waveform_line_b_oe),
   .channel_irq(channel_irq));

// [sim/pin_partner.sv]
// far-side model of the two waveform pins and the trigger pin
`timescale 1ns/1ps
module pin_partner (
   // design drive
   input wire line_a_out,
   input wire line_a_oe,
   input wire line_b_out,
   input wire line_b_oe,
   // levels asked by the bench
   input wire drive_a,
   input wire drive_b,
   input wire trig_level,
   // resolved pins
   output wire line_a_in,
   output wire line_b_in,
   output wire ext_trigger
);
   // partner lets go while the channel drives, so no contention
   assign line_a_in = line_a_oe ? line_a_out : drive_a;
   assign line_b_in = line_b_oe ? line_b_out : drive_b;
   assign ext_trigger = trig_level;
endmodule

// [sim/timer_channel_status_regs_tb.sv]
// self-checking bench of the timer channel register block
`timescale 1ns/1ps
`include "timer_channel_defines.vh"
module timer_channel_status_regs_tb;
   reg clk = 1'b0;
   reg reset = 1'b1;
   reg hsel = 1'b0;
   reg hwrite = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [31:0] hwdata = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg drive_a = 1'b0;
   reg drive_b = 1'b0;
   reg trig_level = 1'b0;
   wire hreadyout, hresp, a_in, a_out, a_oe, b_in, b_out, b_oe, ext_in, channel_irq;
   wire [31:0] hrdata;
   integer n_mismatch = 0;
   integer samples_checked = 0;
   integer cycles = 0;
   integer i;
   reg [31:0] rd, rd2, va, vb, vc;
   reg lvl;
   timer_channel_status_regs timer_channel_status_regs_inst (.clk(clk), .reset(reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .waveform_line_a_in(a_in),
      .waveform_line_a_out(a_out), .waveform_line_a_oe(a_oe), .waveform_line_b_in(b_in),
      .waveform_line_b_out(b_out), .waveform_line_b_oe(b_oe), .ext_trigger_in(ext_in),
      .channel_irq(channel_irq));
   pin_partner pin_partner_inst (.line_a_out(a_out), .line_a_oe(a_oe), .line_b_out(b_out), .line_b_oe(b_oe),
      .drive_a(drive_a), .drive_b(drive_b), .trig_level(trig_level), .line_a_in(a_in), .line_b_in(b_in),
      .ext_trigger(ext_in));
   initial begin
      forever #25 clk = ~clk;
   end
   // ----------------------------------------
   // tasks and expectation
   // ----------------------------------------
   task check(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task bus(input wr, input [31:0] a, input [31:0] d);
      begin
         hsel <= 1'b1;
         htrans <= 2'h2;
         haddr <= a;
         hwrite <= wr;
         @(posedge clk);
         while (hreadyout !== 1'b1) @(posedge clk);
         htrans <= 2'h0;
         hsel <= 1'b0;
         hwdata <= d;
         @(posedge clk);
         while (hreadyout !== 1'b1) @(posedge clk);
         rd = hrdata;
      end
   endtask
   task rdc(input [31:0] a, input [31:0] exp);
      begin
         bus(1'b0, a, 32'h0);
         check(rd, exp);
      end
   endtask
   task peek;
      begin
         @(posedge clk);
         #1;
      end
   endtask
   function exp_line(input [1:0] code, input cur);
      begin
         case (code)
            `EFFECT_SET: exp_line = 1'b1;
            `EFFECT_CLEAR: exp_line = 1'b0;
            `EFFECT_TOGGLE: exp_line = ~cur;
            default: exp_line = cur;
         endcase
      end
   endfunction
   task close_out;
      begin
         $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
         if (n_mismatch == 0 && samples_checked > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         n_mismatch = n_mismatch + 1;
         close_out;
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rd = $urandom(4);
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rdc(`ADDR_CHANNEL_STATUS, 32'h0);
      rdc(`ADDR_COUNTER_VALUE_READBACK, 32'h0);
      rdc(`ADDR_INTERRUPT_MASK, 32'h0);
      $display("test reset_values done");
      vc = $urandom | 32'h80000000;
      bus(1'b1, `ADDR_COMPARE_LIMIT_C, vc);
      rdc(`ADDR_COMPARE_LIMIT_C, vc);
      bus(1'b1, `ADDR_CAPTURE_COMPARE_A, $urandom);
      rdc(`ADDR_CAPTURE_COMPARE_A, 32'h0);
      bus(1'b1, `ADDR_WRITE_PROTECT_MODE, 32'h1);
      bus(1'b1, `ADDR_COMPARE_LIMIT_C, ~vc);
      rdc(`ADDR_COMPARE_LIMIT_C, vc);
      bus(1'b1, `ADDR_STEPPER_GRAY_MODE, 32'h3);
      rdc(`ADDR_STEPPER_GRAY_MODE, 32'h0);
      bus(1'b1, `ADDR_WRITE_PROTECT_MODE, 32'h0);
      $display("test protection done");
      for (i = 0; i < 4; i = i + 1) begin
         va = $urandom;
         vb = $urandom;
         bus(1'b1, `ADDR_INTERRUPT_ENABLE_CLEAR, 32'hff);
         bus(1'b1, `ADDR_INTERRUPT_ENABLE_SET, va);
         bus(1'b1, `ADDR_INTERRUPT_ENABLE_SET, vb);
         rdc(`ADDR_INTERRUPT_MASK, (va | vb) & 32'hff);
         bus(1'b1, `ADDR_INTERRUPT_ENABLE_CLEAR, va);
         rdc(`ADDR_INTERRUPT_MASK, vb & ~va & 32'hff);
      end
      $display("test enables done");
      va = $urandom | 32'h80000000;
      vb = $urandom | 32'h80000000;
      bus(1'b1, `ADDR_CHANNEL_MODE, 32'h8000);
      bus(1'b1, `ADDR_CAPTURE_COMPARE_A, va);
      rdc(`ADDR_CAPTURE_COMPARE_A, va);
      bus(1'b1, `ADDR_CAPTURE_COMPARE_B, vb);
      rdc(`ADDR_CAPTURE_COMPARE_B, vb);
      lvl = 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         rd2 = (i < 4) ? i : $urandom % 4;
         bus(1'b1, `ADDR_CHANNEL_MODE, (rd2 << 30) | 32'h8000);
         bus(1'b1, `ADDR_CHANNEL_CONTROL, 32'h4);
         lvl = exp_line(rd2[1:0], lvl);
         peek;
         check({30'h0, b_out, a_out}, {30'h0, lvl, 1'b0});
         rdc(`ADDR_CHANNEL_STATUS, {13'h0, lvl, 2'h1, 16'h0});
      end
      bus(1'b0, `ADDR_COUNTER_VALUE_READBACK, 32'h0);
      rd2 = rd;
      bus(1'b0, `ADDR_COUNTER_VALUE_READBACK, 32'h0);
      check(rd - rd2, 32'h2);
      bus(1'b1, `ADDR_CHANNEL_CONTROL, 32'h2);
      rdc(`ADDR_CHANNEL_STATUS, {13'h0, lvl, 18'h0});
      $display("test waveform done");
      bus(1'b1, `ADDR_CHANNEL_MODE, 32'h8000);
      bus(1'b1, `ADDR_COMPARE_LIMIT_C, 32'h5);
      bus(1'b1, `ADDR_STEPPER_GRAY_MODE, 32'h1);
      peek;
      check({30'h0, b_out, a_out}, 32'h0);
      bus(1'b1, `ADDR_CHANNEL_CONTROL, 32'h4);
      repeat (20) @(posedge clk);
      check({30'h0, b_out, a_out}, 32'h1);
      bus(1'b1, `ADDR_STEPPER_GRAY_MODE, 32'h3);
      bus(1'b1, `ADDR_CHANNEL_CONTROL, 32'h4);
      repeat (20) @(posedge clk);
      check({30'h0, b_out, a_out}, 32'h0);
      bus(1'b1, `ADDR_STEPPER_GRAY_MODE, 32'h0);
      peek;
      check({30'h0, b_out, a_out}, {30'h0, lvl, 1'b0});
      $display("test gray done");
      bus(1'b0, `ADDR_CHANNEL_STATUS, 32'h0);
      bus(1'b1, `ADDR_INTERRUPT_ENABLE_CLEAR, 32'hff);
      bus(1'b1, `ADDR_INTERRUPT_ENABLE_SET, 32'h10);
      bus(1'b1, `ADDR_CHANNEL_CONTROL, 32'h4);
      repeat (20) @(posedge clk);
      check({31'h0, channel_irq}, 32'h1);
      rdc(`ADDR_CHANNEL_STATUS, {13'h0, lvl, 2'h1, 16'h10});
      peek;
      check({31'h0, channel_irq}, 32'h0);
      rdc(`ADDR_CHANNEL_STATUS, {13'h0, lvl, 2'h1, 16'h0});
      bus(1'b1, `ADDR_COMPARE_LIMIT_C, 32'h0);
      bus(1'b1, `ADDR_CHANNEL_CONTROL, 32'h4);
      rdc(`ADDR_CHANNEL_STATUS, {13'h0, lvl, 2'h1, 16'h0});
      rdc(`ADDR_CHANNEL_STATUS, {13'h0, lvl, 2'h1, 16'h10});
      bus(1'b1, `ADDR_CAPTURE_COMPARE_A, 32'h3);
      bus(1'b1, `ADDR_CAPTURE_COMPARE_B, 32'h4);
      bus(1'b1, `ADDR_CHANNEL_CONTROL, 32'h4);
      repeat (20) @(posedge clk);
      rdc(`ADDR_CHANNEL_STATUS, {13'h0, ~lvl, 2'h3, 16'h1c});
      bus(1'b1, `ADDR_CHANNEL_CONTROL, 32'h2);
      $display("test compare_c done");
      bus(1'b1, `ADDR_CHANNEL_MODE, 32'h0);
      bus(1'b1, `ADDR_COMPARE_LIMIT_C, 32'hffffffff);
      bus(1'b0, `ADDR_CHANNEL_STATUS, 32'h0);
      trig_level <= 1'b1;
      repeat (6) @(posedge clk);
      drive_a <= 1'b1;
      repeat (6) @(posedge clk);
      drive_a <= 1'b0;
      repeat (6) @(posedge clk);
      drive_a <= 1'b1;
      repeat (6) @(posedge clk);
      rdc(`ADDR_CHANNEL_STATUS, 32'h000300e2);
      rdc(`ADDR_CHANNEL_STATUS, 32'h00030000);
      $display("test capture done");
      close_out;
   end
endmodule
